// ### esst_defines.svh
// Constants of the servo sector timing block: register offsets,
// field positions, reset values and timing counts.
// Assumes a 20 MHz hclk and a 32-bit AHB-Lite register bus.
`ifndef ESST_DEFINES_SVH
`define ESST_DEFINES_SVH

// Register byte offsets.
`define ESST_CTRL_OFS      12'h000
`define ESST_CONFIG_OFS    12'h004
`define ESST_TRACK_OFS     12'h008
`define ESST_INTERVAL_OFS  12'h00c
`define ESST_SERVO_LEN_OFS 12'h010
`define ESST_GAP_OFS       12'h014
`define ESST_RPT_GAP_OFS   12'h018
`define ESST_UBPS_OFS      12'h01c
`define ESST_SPT_OFS       12'h020
`define ESST_STATUS_OFS    12'h024
`define ESST_MASK_OFS      12'h028
`define ESST_HSW_OFS       12'h02c
`define ESST_POS_OFS       12'h030

// Field positions.
`define ESST_CTRL_MODE_LSB   0
`define ESST_CTRL_MODE_MSB   1
`define ESST_CFG_LONG_BIT    0
`define ESST_EV_DONE_BIT     0
`define ESST_EV_BLOCK_BIT    1
`define ESST_EV_HSW_BIT      2
`define ESST_EV_SECTOR_BIT   3

// Reset values.
`define ESST_TRACK_RST     16'h4e20
`define ESST_INTERVAL_RST  16'h1388
`define ESST_SERVO_LEN_RST 16'h0030
`define ESST_GAP_RST       16'h0010
`define ESST_UBPS_RST      16'h0465
`define ESST_SPT_RST       16'h0010

// Timing: clock period and the short head switch bound.
`define ESST_CLK_NS        50
`define ESST_SHORT_HSW_NS  15000
`define ESST_HSW_RST       ((`ESST_SHORT_HSW_NS + `ESST_CLK_NS - 1) / `ESST_CLK_NS)

`endif

// ### esst_pkg.sv
// Types of the servo sector timing block.
// Assumes nothing of its surroundings.
package esst_pkg;

    // Servo layout of the data tracks.
    typedef enum logic [1:0] {
        ESST_SERVO_NONE  = 2'b00,
        ESST_SERVO_EVERY = 2'b01,
        ESST_SERVO_SPARSE = 2'b10
    } esst_mode_t;

    // Geometry recompute sequence.
    typedef enum logic [2:0] {
        ESST_IDLE   = 3'b000,
        ESST_N_GO   = 3'b001,
        ESST_N_WAIT = 3'b010,
        ESST_U_GO   = 3'b011,
        ESST_U_WAIT = 3'b100,
        ESST_S_GO   = 3'b101,
        ESST_S_WAIT = 3'b110
    } esst_state_t;

endpackage

// ### esst_div_if.sv
// Request and answer of the serial divider.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface esst_div_if;
    logic        start;
    logic [15:0] dividend;
    logic [15:0] divisor;
    logic        done;
    logic [15:0] quotient;

    modport master (output start, output dividend, output divisor,
                    input done, input quotient);
    modport slave  (input start, input dividend, input divisor,
                    output done, output quotient);
endinterface
`default_nettype wire

// ### esst_div.sv
// Serial restoring divider, sixteen cycles per quotient.
// Assumes a nonzero divisor; a zero divisor yields all ones.
`timescale 1ns/1ps
`default_nettype none
module esst_div (
    // Clock, reset and freeze.
    input  wire logic   hclk,
    input  wire logic   hresetn,
    input  wire logic   ce,
    // Division request and answer.
    esst_div_if.slave   dv
);
    logic [4:0]  count_reg;
    logic [15:0] rem_reg;
    logic [15:0] quo_reg;
    logic [15:0] divs_reg;
    logic        done_reg;
    logic [16:0] trial;
    logic        fits;

    // One quotient bit per cycle.
    assign trial       = {rem_reg, quo_reg[15]};
    assign fits        = trial >= {1'b0, divs_reg};
    assign dv.done     = done_reg;
    assign dv.quotient = quo_reg;

    // The count runs down to zero; done pulses on the last step.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            count_reg <= 5'h00;
            rem_reg   <= 16'h0000;
            quo_reg   <= 16'h0000;
            divs_reg  <= 16'h0000;
            done_reg  <= 1'b0;
        end
        else if (ce)
        begin
            done_reg <= (count_reg == 5'h01);
            if (dv.start)
            begin
                count_reg <= 5'h10;
                rem_reg   <= 16'h0000;
                quo_reg   <= dv.dividend;
                divs_reg  <= dv.divisor;
            end
            else if (count_reg != 5'h00)
            begin
                count_reg <= count_reg - 5'h01;
                rem_reg   <= fits ? 16'(trial - {1'b0, divs_reg})
                                  : trial[15:0];
                quo_reg   <= {quo_reg[14:0], fits};
            end
        end
    end
endmodule // esst_div
`default_nettype wire

// ### esst_timing.sv
// Drive-side servo sector timing: head switch completion, write
// inhibit over servo, sector pulse placement and geometry recompute.
// Assumes byte_tick marks each byte under the head, servo_area is high
// while a servo region passes, and all inputs are synchronous to hclk.
`include "esst_defines.svh"
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Configuration bit reports long head switches
// - Hold command complete low during switch
// - Servo length reported as sector gaps
// - Block writes inside servo regions
// - Sparse servo sits inside sector gaps
// - Sector pulses postponed past servo region
// - Track size reported without servo regions
// - Whole sectors fit between servo regions
// - Spread sector size evenly per interval
// - Defect offsets count bytes excluding servo
// - No servo: accept any geometry
module esst_timing (
    // Clock, reset and freeze.
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         ce,
    // AHB-Lite slave.
    input  wire logic         hsel,
    input  wire logic [31:0]  haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output logic              hreadyout,
    output logic              hresp,
    output logic [31:0]       hrdata,
    // Media timing from the spindle and servo channel.
    input  wire logic         byte_tick,
    input  wire logic         index_in,
    input  wire logic         servo_area,
    // Controller side of the drive interface.
    input  wire logic         head_switch_req,
    input  wire logic         write_gate_in,
    output logic              write_gate_out,
    output logic              cmd_complete,
    output logic              index_out,
    output logic              sector_out,
    output logic              irq
);
    esst_div_if dv ();

    esst_pkg::esst_state_t state_reg;
    esst_pkg::esst_mode_t  mode_reg;
    logic [15:0] track_reg, interval_reg, servo_len_reg, gap_reg;
    logic [15:0] ubps_reg, spt_reg, req_reg, n_reg, hsw_reg;
    logic [15:0] byte_cnt_reg, pos_reg, hsw_cnt_reg;
    logic [3:0]  status_reg, mask_reg, events;
    logic        index_reg, sector_reg, rdata_sel;
    logic [11:0] addr_reg;
    logic        wr_reg;
    logic        long_sw, servo_on, addr_ok, wr_go;
    logic        sector_fire, calc_done, blocked;
    logic [15:0] inter_sector_gap, ubps_last, n_clamped;
    logic [31:0] rdata_mux;

    // Bus decode; the slave never stalls and always answers OKAY.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign addr_ok   = hsel & htrans[1] & hready;
    assign wr_go     = wr_reg & ce;
    assign servo_on  = mode_reg != esst_pkg::ESST_SERVO_NONE;
    assign long_sw   = servo_on;
    assign inter_sector_gap = (mode_reg == esst_pkg::ESST_SERVO_EVERY)
                            ? servo_len_reg : gap_reg;
    assign ubps_last = ubps_reg - 16'h0001;
    assign n_clamped = (dv.quotient == 16'h0000) ? 16'h0001 : dv.quotient;

    assign write_gate_out = write_gate_in & ~servo_area;
    assign blocked        = write_gate_in & servo_area;
    assign sector_fire = byte_tick & ~servo_area & ~index_in
                       & (byte_cnt_reg == ubps_last);
    assign calc_done   = (state_reg == esst_pkg::ESST_S_WAIT) & dv.done;
    assign cmd_complete = (hsw_cnt_reg == 16'h0000);
    assign index_out   = index_reg;
    assign sector_out  = sector_reg;
    assign irq         = |(status_reg & mask_reg);
    assign events = {sector_fire,
                     long_sw & head_switch_req & cmd_complete,
                     blocked, calc_done};

    // Divider operands follow the recompute step.
    assign dv.start = (state_reg == esst_pkg::ESST_N_GO)
                    | (state_reg == esst_pkg::ESST_U_GO)
                    | (state_reg == esst_pkg::ESST_S_GO);
    assign dv.dividend = (state_reg == esst_pkg::ESST_S_GO)
                       ? track_reg : interval_reg;
    assign dv.divisor  = (state_reg == esst_pkg::ESST_N_GO) ? req_reg
                       : (state_reg == esst_pkg::ESST_U_GO) ? n_reg
                       : ubps_reg;

    esst_div u_div (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .dv      (dv)
    );

    // Read data selection; unmapped offsets read as zero.
    always_comb
    begin
        rdata_mux = 32'h0000_0000;
        unique case (haddr[11:0])
            `ESST_CTRL_OFS:      rdata_mux[1:0] = mode_reg;
            `ESST_CONFIG_OFS:    rdata_mux[`ESST_CFG_LONG_BIT] = long_sw;
            `ESST_TRACK_OFS:     rdata_mux[15:0] = track_reg;
            `ESST_INTERVAL_OFS:  rdata_mux[15:0] = interval_reg;
            `ESST_SERVO_LEN_OFS: rdata_mux[15:0] = servo_len_reg;
            `ESST_GAP_OFS:       rdata_mux[15:0] = gap_reg;
            `ESST_RPT_GAP_OFS:   rdata_mux[15:0] = inter_sector_gap;
            `ESST_UBPS_OFS:      rdata_mux[15:0] = ubps_reg;
            `ESST_SPT_OFS:       rdata_mux[15:0] = spt_reg;
            `ESST_STATUS_OFS:    rdata_mux[3:0] = status_reg;
            `ESST_MASK_OFS:      rdata_mux[3:0] = mask_reg;
            `ESST_HSW_OFS:       rdata_mux[15:0] = hsw_reg;
            `ESST_POS_OFS:       rdata_mux[15:0] = pos_reg;
            default:             rdata_mux = 32'h0000_0000;
        endcase
    end

    // Address phase capture; read data is registered for the data phase.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            addr_reg  <= 12'h000;
            wr_reg    <= 1'b0;
            hrdata    <= 32'h0000_0000;
            rdata_sel <= 1'b0;
        end
        else if (ce)
        begin
            addr_reg  <= haddr[11:0];
            wr_reg    <= addr_ok & hwrite;
            rdata_sel <= addr_ok & ~hwrite;
            if (addr_ok & ~hwrite)
                hrdata <= rdata_mux;
        end
    end

    // Software registers. The track size is the servo-exclusive figure.
    // servo excluded size
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mode_reg      <= esst_pkg::ESST_SERVO_NONE;
            track_reg     <= `ESST_TRACK_RST;
            interval_reg  <= `ESST_INTERVAL_RST;
            servo_len_reg <= `ESST_SERVO_LEN_RST;
            gap_reg       <= `ESST_GAP_RST;
            mask_reg      <= 4'h0;
            hsw_reg       <= 16'(`ESST_HSW_RST);
        end
        else if (wr_go)
        begin
            unique case (addr_reg)
                `ESST_CTRL_OFS:
                    mode_reg <= esst_pkg::esst_mode_t'(hwdata[1:0]);
                `ESST_TRACK_OFS:     track_reg     <= hwdata[15:0];
                `ESST_INTERVAL_OFS:  interval_reg  <= hwdata[15:0];
                `ESST_SERVO_LEN_OFS: servo_len_reg <= hwdata[15:0];
                `ESST_GAP_OFS:       gap_reg       <= hwdata[15:0];
                `ESST_MASK_OFS:      mask_reg      <= hwdata[3:0];
                `ESST_HSW_OFS:       hsw_reg       <= hwdata[15:0];
                default:             mode_reg      <= mode_reg;
            endcase
        end
    end

    // Sticky events; a new event wins over a write-one clear.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            status_reg <= 4'h0;
        else if (ce)
            status_reg <= (status_reg
                & ~((wr_reg && addr_reg == `ESST_STATUS_OFS)
                    ? hwdata[3:0] : 4'h0)) | events;
    end

    // Head switch timer; short-switch drives never drop completion.
    // completion held low
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hsw_cnt_reg <= 16'h0000;
        else if (ce)
        begin
            if (long_sw & head_switch_req)
                hsw_cnt_reg <= (hsw_reg == 16'h0000) ? 16'h0001 : hsw_reg;
            else if (hsw_cnt_reg != 16'h0000)
                hsw_cnt_reg <= hsw_cnt_reg - 16'h0001;
        end
    end

    // Byte counters restart at index and freeze over servo regions.
    // restart and freeze
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            byte_cnt_reg <= 16'h0000;
            pos_reg      <= 16'h0000;
            index_reg    <= 1'b0;
            sector_reg   <= 1'b0;
        end
        else if (ce)
        begin
            index_reg  <= index_in;
            sector_reg <= sector_fire;
            if (index_in)
            begin
                byte_cnt_reg <= 16'h0000;
                pos_reg      <= 16'h0000;
            end
            else if (byte_tick & ~servo_area)
            begin
                byte_cnt_reg <= sector_fire ? 16'h0000
                                            : byte_cnt_reg + 16'h0001;
                pos_reg      <= pos_reg + 16'h0001;
            end
        end
    end

    // Geometry recompute on a write of the requested sector size.
    // A servo drive fits n whole sectors per interval and spreads
    // the remainder; a servo-free drive takes the request as is.
    // whole sectors
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_reg <= esst_pkg::ESST_IDLE;
            req_reg   <= `ESST_UBPS_RST;
            ubps_reg  <= `ESST_UBPS_RST;
            n_reg     <= 16'h0001;
            spt_reg   <= `ESST_SPT_RST;
        end
        else if (ce)
        begin
            unique case (state_reg)
                esst_pkg::ESST_IDLE:
                    if (wr_reg && addr_reg == `ESST_UBPS_OFS)
                    begin
                        req_reg   <= (hwdata[15:0] == 16'h0000)
                                   ? 16'h0001 : hwdata[15:0];
                        state_reg <= servo_on ? esst_pkg::ESST_N_GO
                                              : esst_pkg::ESST_S_GO;
                        if (!servo_on)
                            ubps_reg <= (hwdata[15:0] == 16'h0000)
                                      ? 16'h0001 : hwdata[15:0];
                    end
                esst_pkg::ESST_N_GO:
                    state_reg <= esst_pkg::ESST_N_WAIT;
                esst_pkg::ESST_N_WAIT:
                    if (dv.done)
                    begin
                        n_reg     <= n_clamped;
                        state_reg <= esst_pkg::ESST_U_GO;
                    end
                esst_pkg::ESST_U_GO:
                    state_reg <= esst_pkg::ESST_U_WAIT;
                esst_pkg::ESST_U_WAIT:
                    if (dv.done)
                    begin
                        ubps_reg  <= n_clamped;
                        state_reg <= esst_pkg::ESST_S_GO;
                    end
                esst_pkg::ESST_S_GO:
                    state_reg <= esst_pkg::ESST_S_WAIT;
                esst_pkg::ESST_S_WAIT:
                    if (dv.done)
                    begin
                        spt_reg   <= dv.quotient;
                        state_reg <= esst_pkg::ESST_IDLE;
                    end
                default:
                    state_reg <= esst_pkg::ESST_IDLE;
            endcase
        end
    end

    // Checks beside the logic.
    sequence switch_asked;
        ce && long_sw && head_switch_req;
    endsequence
    sequence held_low;
        !cmd_complete [*2];
    endsequence

    write_block_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        servo_area |-> !write_gate_out)
        else $error("write gate passed into servo region");
    switch_hold_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        switch_asked ##0 (hsw_reg > 16'h0002) |=> held_low)
        else $error("command complete not held during switch");
    short_switch_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !long_sw && cmd_complete |=> cmd_complete || $past(long_sw))
        else $error("short switch drive dropped completion");
    gap_report_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        mode_reg == esst_pkg::ESST_SERVO_EVERY
            |-> inter_sector_gap == servo_len_reg)
        else $error("gap does not report servo length");
    sector_place_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ce && sector_out |-> $past(!servo_area && byte_tick))
        else $error("sector pulse inside servo region");
    index_restart_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ce && index_in |=> byte_cnt_reg == 16'h0000 && pos_reg == 16'h0000)
        else $error("counter did not restart at index");
    servo_freeze_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ce && servo_area && !index_in |=> $stable(pos_reg)
            && $stable(byte_cnt_reg))
        else $error("counters moved over servo region");
    whole_fit_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        calc_done && servo_on |-> 32'(n_reg) * 32'(ubps_reg)
            <= 32'(interval_reg) || n_reg == 16'h0001)
        else $error("sectors overrun the servo interval");
    even_spread_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        calc_done && servo_on && n_reg > 16'h0000 |->
            32'(interval_reg) - 32'(n_reg) * 32'(ubps_reg) < 32'(n_reg)
            || 32'(n_reg) * 32'(ubps_reg) > 32'(interval_reg))
        else $error("remainder left in servo interval");
    free_geom_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        calc_done && !servo_on |-> ubps_reg == req_reg)
        else $error("servo-free drive altered sector size");
endmodule // esst_timing
`default_nettype wire

// ### esst_ctrl_model.sv
// Controller and media model facing the servo sector timing block.
// Assumes one hclk; the bench commands switches and the write gate.
`timescale 1ns/1ps
`default_nettype none
module esst_ctrl_model #(
    parameter int IV = 44,
    parameter int SL = 8
) (
    // Clock and reset.
    input  wire logic hclk,
    input  wire logic hresetn,
    // Bench commands.
    input  wire logic run,
    input  wire logic sw_go,
    input  wire logic wr_hold,
    // Drive side.
    input  wire logic cmd_complete,
    output logic      byte_tick,
    output logic      index_in,
    output logic      servo_area,
    output logic      head_switch_req,
    output logic      write_gate_in
);
    int   p;
    logic pend;
    logic low_seen;

    // One byte a cycle; IV data bytes then SL servo bytes, four per track.
    // The servo spacing differs from the block's register on purpose.
    assign byte_tick  = run;
    assign index_in   = run && (p == 0);
    assign servo_area = run && ((p % (IV + SL)) >= IV);

    assign write_gate_in = wr_hold && !pend;

    // Track position and the wait for completion after a switch.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            p <= 0;
            pend <= 1'b0;
            low_seen <= 1'b0;
            head_switch_req <= 1'b0;
        end
        else
        begin
            if (run)
                p <= (p + 1) % (4 * (IV + SL));
            head_switch_req <= sw_go;
            if (sw_go)
                pend <= 1'b1;
            if (pend && !cmd_complete)
                low_seen <= 1'b1;
            if (pend && low_seen && cmd_complete)
            begin
                pend <= 1'b0;
                low_seen <= 1'b0;
            end
        end
    end
endmodule // esst_ctrl_model
`default_nettype wire

// ### testbench.sv
// Self-checking bench of the servo sector timing block.
// Assumes the block answers the bus with zero wait states.
`include "esst_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        hclk, hresetn, ce, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rdum;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        byte_tick, index_in, servo_area, head_switch_req;
    logic        write_gate_in, write_gate_out, cmd_complete;
    logic        index_out, sector_out, irq;
    logic        run, sw_go, wr_hold, rd_phase, armed, idx_d;
    int          fails, num_checks, gap, nsec, pos, lows, r;
    logic [31:0] exp_q[$];
    logic [11:0] ofs [13] = '{12'h004, 12'h008, 12'h00c, 12'h010,
        12'h014, 12'h018, 12'h01c, 12'h020, 12'h024, 12'h028,
        12'h02c, 12'h030, 12'h040};
    logic [31:0] rv [13] = '{32'h0, 32'h4e20, 32'h1388, 32'h30,
        32'h10, 32'h10, 32'h465, 32'h10, 32'h0, 32'h0, 32'h12c,
        32'h0, 32'h0};

    esst_timing DUT (.hclk(hclk), .hresetn(hresetn), .ce(ce),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .byte_tick(byte_tick), .index_in(index_in),
        .servo_area(servo_area), .head_switch_req(head_switch_req),
        .write_gate_in(write_gate_in), .write_gate_out(write_gate_out),
        .cmd_complete(cmd_complete), .index_out(index_out),
        .sector_out(sector_out), .irq(irq));

    esst_ctrl_model partner (.hclk(hclk), .hresetn(hresetn), .run(run),
        .sw_go(sw_go), .wr_hold(wr_hold), .cmd_complete(cmd_complete),
        .byte_tick(byte_tick), .index_in(index_in),
        .servo_area(servo_area), .head_switch_req(head_switch_req),
        .write_gate_in(write_gate_in));

    // Free-running bus clock.
    initial
    begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: %h vs %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        if (fails == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // One single word transfer; the address phase holds until hready.
    task automatic bus(input logic [11:0] a, input logic w,
                       input logic [31:0] d, input logic c,
                       output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rd_phase <= !w && c;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
        rd_phase <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(a, 1'b1, d, 1'b0, rdum);
    endtask

    // The expected word is queued for the monitor before the read.
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(a, 1'b0, 32'h0, 1'b1, rdum);
    endtask

    // Polls completion, clears it, then reads back what was adopted.
    task automatic geo(input int req, input int ub, input int sp);
        int k;
        wr(`ESST_UBPS_OFS, req);
        rdum = 32'h0;
        for (k = 0; k < 100 && rdum[0] !== 1'b1; k++)
            bus(`ESST_STATUS_OFS, 1'b0, 32'h0, 1'b0, rdum);
        check(rdum[0], 1'b1);
        wr(`ESST_STATUS_OFS, 32'h1);
        rd(`ESST_UBPS_OFS, ub);
        rd(`ESST_SPT_OFS, sp);
    endtask

    // Output monitor: read data, sector spacing, gate and index copy.
    always @(posedge hclk)
    begin
        if (rd_phase)
            check(hrdata, exp_q.pop_front());
        // The index copy is only defined once reset has been seen.
        if (hresetn)
        begin
            check(write_gate_out, write_gate_in & !servo_area);
            check(index_out, idx_d);
        end
        idx_d <= index_in;
        if (index_in && byte_tick)
            pos <= 0;
        else if (byte_tick && !servo_area)
            pos <= pos + 1;
        if (sector_out)
        begin
            if (armed)
                check(gap, 10);
            nsec++;
            armed <= !index_in;
            gap <= (byte_tick && !servo_area) ? 1 : 0;
        end
        else if (index_in)
            armed <= 1'b0;
        else if (byte_tick && !servo_area)
            gap <= gap + 1;
    end

    // Watchdog well beyond the expected run length.
    initial
    begin
        #2000000;
        fails++;
        summarize();
    end

    initial
    begin
        {hresetn, hsel, hwrite, haddr, htrans, hwdata} = '0;
        {run, sw_go, wr_hold, rd_phase, armed, idx_d} = '0;
        {fails, num_checks, gap, nsec, pos} = '0;
        ce = 1'b1;
        hsize = 3'h2;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        void'($urandom(32'he2b7));
        // Reset values, the unmapped word last.
        foreach (ofs[i])
            rd(ofs[i], rv[i]);
        // Each servo mode: long switch flag and reported gap.
        for (int m = 0; m < 3; m++)
        begin
            wr(`ESST_CTRL_OFS, m);
            rd(`ESST_CONFIG_OFS, m != 0);
            rd(`ESST_RPT_GAP_OFS, (m == 1) ? 32'h30 : 32'h10);
        end
        wr(`ESST_CTRL_OFS, 32'h0);
        r = 300 + $urandom % 1900;
        geo(r, r, 20000 / r);
        wr(`ESST_CTRL_OFS, 32'h1);
        geo(1024, 1250, 16);
        r = 100 + $urandom % 4900;
        geo(r, 5000 / (5000 / r), 20000 / (5000 / (5000 / r)));
        // Short track for the media run.
        wr(`ESST_TRACK_OFS, 32'ha0);
        wr(`ESST_INTERVAL_OFS, 32'h28);
        wr(`ESST_SERVO_LEN_OFS, 32'h8);
        wr(`ESST_CTRL_OFS, 32'h2);
        geo(10, 10, 16);
        // Head switch with its interrupt unmasked.
        wr(`ESST_HSW_OFS, 32'ha);
        wr(`ESST_MASK_OFS, 32'h4);
        sw_go <= 1'b1;
        @(posedge hclk);
        sw_go <= 1'b0;
        lows = 0;
        repeat (30)
        begin
            @(posedge hclk);
            if (cmd_complete === 1'b0)
                lows++;
        end
        check(lows, 10);
        check(irq, 1'b1);
        wr(`ESST_STATUS_OFS, 32'h4);
        @(posedge hclk);
        check(irq, 1'b0);
        // Media with the write gate held across servo regions.
        wr_hold <= 1'b1;
        run <= 1'b1;
        repeat (400) @(posedge hclk);
        run <= 1'b0;
        wr_hold <= 1'b0;
        repeat (3) @(posedge hclk);
        check(nsec >= 25, 1'b1);
        rd(`ESST_POS_OFS, pos);
        rd(`ESST_STATUS_OFS, 32'ha);
        // With the clock enable low a write must not land.
        ce <= 1'b0;
        wr(`ESST_GAP_OFS, 32'h55);
        ce <= 1'b1;
        rd(`ESST_GAP_OFS, 32'h10);
        summarize();
    end
endmodule // testbench
`default_nettype wire
